// *** rtl/smc_pkg.sv ***
// Package of constants and types for the sleep mode controller.
package smc_pkg;

   // Register offsets on the plain register port.
   localparam logic [0:0] SMC_OFS_SLEEP_CTRL = 1'h0;
   localparam logic [0:0] SMC_OFS_REG_CTRL   = 1'h1;

   // Field positions.
   localparam int SMC_SLEEP_ALLOW_BIT = 0;
   localparam int SMC_SELECT_LSB      = 1;
   localparam int SMC_SELECT_MSB      = 3;
   localparam int SMC_LEAK_CUT_BIT    = 4;
   localparam int SMC_DRIVE_LSB       = 0;
   localparam int SMC_DRIVE_MSB       = 2;

   // Reset values.
   localparam logic [7:0] SMC_SLEEP_CTRL_RST = 8'h00;
   localparam logic [7:0] SMC_REG_CTRL_RST   = 8'h00;

   // Sleep select encodings.
   localparam logic [2:0] SMC_SEL_IDLE    = 3'h0;
   localparam logic [2:0] SMC_SEL_STANDBY = 3'h1;
   localparam logic [2:0] SMC_SEL_POWER_DOWN_MODE   = 3'h2;

   // Regulator drive encodings.
   localparam logic [1:0] SMC_DRV_AUTO = 2'h0;
   localparam logic [2:0] SMC_DRV_AUTO3 = 3'h0;
   localparam logic [2:0] SMC_DRV_FULL  = 3'h1;

   // Brown-out monitor setting that extends wake-up until ready.
   localparam logic [1:0] SMC_BOD_WAIT_SETTING = 2'h3;

   // Fixed wake-up delay in peripheral clock cycles.
   localparam int         SMC_WAKE_CYCLES = 6;
   localparam logic [3:0] SMC_WAKE_CNT    = 4'(SMC_WAKE_CYCLES);

   // Key window, counted in CPU instructions.
   localparam int         SMC_KEY_WINDOW = 4;
   localparam logic [2:0] SMC_KEY_CNT    = 3'(SMC_KEY_WINDOW);

   // Power states of the sequencer.
   typedef enum logic [2:0] {
      SMC_ACTIVE,
      SMC_IDLE,
      SMC_STANDBY,
      SMC_POWER_DOWN_MODE,
      SMC_WAKE_OSC,
      SMC_WAKE_FIX,
      SMC_WAKE_BOD
   } smc_state_t;

   // Register access request.
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [0:0] addr;
      logic [7:0] wdata;
   } smc_bus_t;

   // Clock and regulator controls driven to the rest of the chip.
   typedef struct packed {
      logic cpuRun;
      logic mainClkRun;
      logic hfClkRun;
      logic slowOscOnly;
      logic regFull;
      logic leakCut;
   } smc_pwr_t;

endpackage

// *** rtl/smc_sleep_mode_controller.sv ***
// Sleep mode controller: mode registers, wake-up sequencer and protected regulator control.
// What this block does
// - Wake delay: six cycles plus osc, regulator.
// - Idle keeps main clock; six cycles only.
// - Standby/Power-Down wake adds oscillator, regulator start.
// - Power-Down stops all but slow oscillator.
// - Brown-out setting 3 extends wake until ready.
// - Runs normally during run-time debugging.
// - Debug break wakes device to Active.
// - Regulator write needs key within four instructions.
// - Unkeyed regulator write leaves contents unchanged.
// - Select field: Idle, Standby, Power-Down encodings.
// - Sleep instruction enters mode only if allowed.
// - Leakage cut acts only with automatic drive.
// - Automatic drive: full unless slow source, low sleep.
// - Full drive keeps maximum strength always.
// - Idle stops CPU; any interrupt wakes.
// - Standby stops fast clocks unless run-in-standby.
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps

module smc_sleep_mode_controller
   import smc_pkg::*;
(
   input  wire logic       core_clk,
   input  wire logic       reset,
   input  wire smc_bus_t   bus,
   output logic [7:0]      rdata,
   input  wire logic       sleepInstr,
   input  wire logic       instrRetired,
   input  wire logic       keyWritten,
   input  wire logic       wakeIdleReq,
   input  wire logic       wakeStandbyReq,
   input  wire logic       wakePdownReq,
   input  wire logic       debugBreak,
   input  wire logic       runInStandby,
   input  wire logic       slowSourceSel,
   input  wire logic [1:0] bodActiveSetting,
   input  wire logic       bodReady,
   input  wire logic       oscReady,
   input  wire logic       regReady,
   output smc_pwr_t        pwr,
   output smc_state_t      stateOut
);

   // Pin-level readiness signals come from other domains and are synchronised first.
   logic [1:0] bodSync_reg;
   logic [1:0] oscSync_reg;
   logic [1:0] regSync_reg;
   logic       bodOk;
   logic       oscOk;
   logic       regOk;

   // Two flip-flop synchronisers; only the second stage is read.
   always_ff @(posedge core_clk) begin
      if (reset) begin
         bodSync_reg <= 2'h0;
         oscSync_reg <= 2'h0;
         regSync_reg <= 2'h0;
      end else begin
         bodSync_reg <= {bodSync_reg[0], bodReady};
         oscSync_reg <= {oscSync_reg[0], oscReady};
         regSync_reg <= {regSync_reg[0], regReady};
      end
   end
   assign bodOk = bodSync_reg[1];
   assign oscOk = oscSync_reg[1];
   assign regOk = regSync_reg[1];

   logic [7:0] sleepCtrl_reg;
   logic [7:0] regCtrl_reg;
   logic [2:0] keyLeft_reg;
   logic       writeSleep;
   logic       writeReg;
   logic       keyOpen;

   assign writeSleep = bus.wr && (bus.addr == SMC_OFS_SLEEP_CTRL);
   assign writeReg   = bus.wr && (bus.addr == SMC_OFS_REG_CTRL);
   assign keyOpen    = (keyLeft_reg != 3'h0);

   // Key window opens on the key write and closes after four retired instructions.
   always_ff @(posedge core_clk) begin
      if (reset) begin
         keyLeft_reg <= 3'h0;
      end else if (keyWritten) begin
         keyLeft_reg <= SMC_KEY_CNT;
      end else if (writeReg) begin
         keyLeft_reg <= 3'h0; // One protected write per key.
      end else if (instrRetired && keyOpen) begin
         keyLeft_reg <= keyLeft_reg - 3'h1;
      end
   end

   // Sleep control register; only the defined bits are stored.
   always_ff @(posedge core_clk) begin
      if (reset) begin
         sleepCtrl_reg <= SMC_SLEEP_CTRL_RST;
      end else if (writeSleep) begin
         sleepCtrl_reg <= {4'h0, bus.wdata[SMC_SELECT_MSB:SMC_SLEEP_ALLOW_BIT]};
      end
   end

   // Regulator control only changes inside an open key window.
   always_ff @(posedge core_clk) begin
      if (reset) begin
         regCtrl_reg <= SMC_REG_CTRL_RST;
      end else if (writeReg && keyOpen) begin
         regCtrl_reg <= {3'h0, bus.wdata[SMC_LEAK_CUT_BIT], 1'h0,
                         bus.wdata[SMC_DRIVE_MSB:SMC_DRIVE_LSB]};
      end
   end

   // Read data is registered and valid the cycle after the read strobe.
   always_ff @(posedge core_clk) begin
      if (reset) begin
         rdata <= 8'h00;
      end else if (bus.rd) begin
         rdata <= (bus.addr == SMC_OFS_SLEEP_CTRL) ? sleepCtrl_reg : regCtrl_reg;
      end else begin
         rdata <= 8'h00;
      end
   end

   logic [2:0] selMode;
   logic [2:0] drive;
   logic       leakBit;
   assign selMode = sleepCtrl_reg[SMC_SELECT_MSB:SMC_SELECT_LSB];
   assign drive   = regCtrl_reg[SMC_DRIVE_MSB:SMC_DRIVE_LSB];
   assign leakBit = regCtrl_reg[SMC_LEAK_CUT_BIT];

   smc_state_t state_reg;
   logic [3:0] wakeCnt_reg;
   logic       wakeReq;

   // Only wake sources permitted in the current mode count; a debug break always wakes.
   always_comb begin
      wakeReq = debugBreak;
      unique case (state_reg)
         SMC_IDLE:    wakeReq = debugBreak || wakeIdleReq;
         SMC_STANDBY: wakeReq = debugBreak || wakeStandbyReq;
         SMC_POWER_DOWN_MODE:   wakeReq = debugBreak || wakePdownReq;
         default:     wakeReq = 1'b0;
      endcase
   end

   // Sequencer; reserved select codes do not enter sleep. Debug changes nothing else.
   always_ff @(posedge core_clk) begin
      if (reset) begin
         state_reg   <= SMC_ACTIVE;
         wakeCnt_reg <= 4'h0;
      end else begin
         unique case (state_reg)
            SMC_ACTIVE: begin
               if (sleepInstr && sleepCtrl_reg[SMC_SLEEP_ALLOW_BIT]) begin
                  if (selMode == SMC_SEL_IDLE) begin
                     state_reg <= SMC_IDLE;
                  end else if (selMode == SMC_SEL_STANDBY) begin
                     state_reg <= SMC_STANDBY;
                  end else if (selMode == SMC_SEL_POWER_DOWN_MODE) begin
                     state_reg <= SMC_POWER_DOWN_MODE;
                  end
               end
            end
            SMC_IDLE: begin
               if (wakeReq) begin
                  state_reg   <= SMC_WAKE_FIX;
                  wakeCnt_reg <= SMC_WAKE_CNT;
               end
            end
            SMC_STANDBY, SMC_POWER_DOWN_MODE: begin
               if (wakeReq) begin
                  state_reg <= SMC_WAKE_OSC;
               end
            end
            SMC_WAKE_OSC: begin
               if (oscOk && regOk) begin
                  state_reg   <= SMC_WAKE_FIX;
                  wakeCnt_reg <= SMC_WAKE_CNT;
               end
            end
            SMC_WAKE_FIX: begin
               if (wakeCnt_reg > 4'h1) begin
                  wakeCnt_reg <= wakeCnt_reg - 4'h1;
               end else if ((bodActiveSetting == SMC_BOD_WAIT_SETTING) && !bodOk) begin
                  state_reg <= SMC_WAKE_BOD;
               end else begin
                  state_reg <= SMC_ACTIVE;
               end
            end
            SMC_WAKE_BOD: begin
               if (bodOk) begin
                  state_reg <= SMC_ACTIVE;
               end
            end
            default: state_reg <= SMC_ACTIVE;
         endcase
      end
   end

   // Registered power controls; the leakage cut output is gated off in hardware outside Power-Down.
   always_ff @(posedge core_clk) begin
      if (reset) begin
         pwr      <= '{cpuRun: 1'b1, mainClkRun: 1'b1, hfClkRun: 1'b1, slowOscOnly: 1'b0,
                       regFull: 1'b1, leakCut: 1'b0};
         stateOut <= SMC_ACTIVE;
      end else begin
         stateOut        <= state_reg;
         pwr.cpuRun      <= (state_reg == SMC_ACTIVE);
         pwr.mainClkRun  <= (state_reg == SMC_STANDBY) ? runInStandby :
                            !(state_reg == SMC_POWER_DOWN_MODE) && (state_reg != SMC_WAKE_OSC);
         pwr.hfClkRun    <= (state_reg == SMC_STANDBY) ? runInStandby :
                            (state_reg != SMC_POWER_DOWN_MODE);
         pwr.slowOscOnly <= (state_reg == SMC_POWER_DOWN_MODE);
         if (drive == SMC_DRV_FULL) begin
            pwr.regFull <= 1'b1;
         end else begin
            pwr.regFull <= (state_reg != SMC_STANDBY) && (state_reg != SMC_POWER_DOWN_MODE)
                           && !slowSourceSel;
         end
         pwr.leakCut <= leakBit && (drive == SMC_DRV_AUTO3)
                        && (state_reg == SMC_POWER_DOWN_MODE);
      end
   end

endmodule // smc_sleep_mode_controller

// *** verification/sleep_mode_controller_test.sv ***
// Self-checking bench for the sleep mode controller.
`timescale 1ns/1ps
module sleep_mode_controller_test;
   import smc_pkg::*;
   logic       core_clk = 1'b0, reset = 1'b1, sleepInstr = 1'b0, instrRetired = 1'b0;
   logic       keyWritten = 1'b0, wakeIdleReq = 1'b0, wakeStandbyReq = 1'b0;
   logic       wakePdownReq = 1'b0, debugBreak = 1'b0, runInStandby = 1'b0;
   logic       slowSourceSel = 1'b0, oscReady, regReady, bodReady;
   logic [1:0] bodActiveSetting = 2'h0;
   logic [7:0] rdata, v, w, oscDly = 8'h0A, bodDly = 8'h00;
   smc_bus_t   bus = '0;
   smc_pwr_t   pwr;
   smc_state_t stateOut;
   int         n_errors = 0, tests_run = 0, n;
   smc_sleep_mode_controller smc_sleep_mode_controller_inst (.core_clk, .reset, .bus, .rdata,
      .sleepInstr, .instrRetired, .keyWritten, .wakeIdleReq, .wakeStandbyReq, .wakePdownReq,
      .debugBreak, .runInStandby, .slowSourceSel, .bodActiveSetting, .bodReady, .oscReady,
      .regReady, .pwr, .stateOut);
   smc_partner_model smc_partner_model_inst (.core_clk, .reset, .stateOut, .oscDly, .bodDly,
      .oscReady, .regReady, .bodReady);
   always #5 core_clk = ~core_clk;
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chkS(input smc_state_t got, input smc_state_t exp);
      chk({5'h00, got}, {5'h00, exp});
   endtask
   task automatic tally_and_finish;
      $display("mismatches %0d of %0d checks", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic wr(input logic a, input logic [7:0] d);
      @(posedge core_clk) bus <= '{1'b1, 1'b0, a, d};
      @(posedge core_clk) bus <= '0;
   endtask
   // Read data stand only in the cycle after the strobe, so sample just past that edge.
   task automatic rd(input logic a, output logic [7:0] d);
      @(posedge core_clk) bus <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge core_clk) bus <= '0;
      #1 d = rdata;
   endtask
   // Opens the key window, then retires k instructions back to back (k at least 1).
   task automatic key(input int k);
      @(posedge core_clk) keyWritten <= 1'b1;
      @(posedge core_clk) keyWritten <= 1'b0;
      instrRetired <= 1'b1;
      repeat (k) @(posedge core_clk);
      instrRetired <= 1'b0;
   endtask
   function automatic smc_state_t expSt(input logic [2:0] s);
      case (s)
         SMC_SEL_IDLE: return SMC_IDLE;
         SMC_SEL_STANDBY: return SMC_STANDBY;
         SMC_SEL_POWER_DOWN_MODE: return SMC_POWER_DOWN_MODE;
         default: return SMC_ACTIVE;
      endcase
   endfunction
   // Shortest legal wake time in cycles for a mode and the brown-out setting.
   function automatic int wmin(input logic [2:0] s);
      int t;
      t = (s == SMC_SEL_IDLE) ? 6 : 6 + int'(oscDly);
      if (bodActiveSetting == SMC_BOD_WAIT_SETTING && int'(bodDly) > t) begin
         t = int'(bodDly);
      end
      return t;
   endfunction
   task automatic goSleep(input logic [2:0] s, input logic en);
      wr(1'b0, {4'h0, s, en});
      @(posedge core_clk) sleepInstr <= 1'b1;
      @(posedge core_clk) sleepInstr <= 1'b0;
      repeat (3) @(posedge core_clk);
      #1 chkS(stateOut, en ? expSt(s) : SMC_ACTIVE);
   endtask
   // Holds one wake source (3 is the debug break) until Active, bounded.
   task automatic wake(input int k, input logic [2:0] s);
      {debugBreak, wakePdownReq, wakeStandbyReq, wakeIdleReq} <= 4'h1 << k;
      n = 0;
      do begin
         @(posedge core_clk);
         #1 n++;
      end while (stateOut !== SMC_ACTIVE && n < 300);
      {debugBreak, wakePdownReq, wakeStandbyReq, wakeIdleReq} <= 4'h0;
      if (n >= 300) begin
         n_errors++;
         tally_and_finish();
      end
      chk(8'(n >= wmin(s) && n <= wmin(s) + 10), 8'h01);
   endtask
   initial begin
      void'($urandom(32'h12595EA1));
      repeat (12) @(posedge core_clk);
      reset <= 1'b0;
      rd(1'b0, v);
      chk(v, SMC_SLEEP_CTRL_RST);
      rd(1'b1, v);
      chk(v, SMC_REG_CTRL_RST);
      repeat (4) begin
         w = 8'($urandom);
         wr(1'b0, w);
         rd(1'b0, v);
         chk(v, w & 8'h0F);
      end
      goSleep(SMC_SEL_IDLE, 1'b0);
      for (int s = 0; s < 8; s++) begin
         runInStandby <= 1'($urandom);
         goSleep(3'(s), 1'b1);
         if (s < 3) wake(s, 3'(s));
      end
      goSleep(SMC_SEL_POWER_DOWN_MODE, 1'b1);
      wake(3, SMC_SEL_POWER_DOWN_MODE);
      bodActiveSetting <= SMC_BOD_WAIT_SETTING;
      bodDly <= 8'd20 + 8'($urandom % 20);
      goSleep(SMC_SEL_IDLE, 1'b1);
      wake(0, SMC_SEL_IDLE);
      bodDly <= 8'h00;
      goSleep(SMC_SEL_IDLE, 1'b1);
      wake(0, SMC_SEL_IDLE);
      bodActiveSetting <= 2'h0;
      wr(1'b1, 8'h11);
      rd(1'b1, v);
      chk(v, 8'h00);
      key(3);
      wr(1'b1, 8'hFF);
      rd(1'b1, v);
      chk(v, 8'h17);
      wr(1'b1, 8'h00);
      key(4);
      wr(1'b1, 8'h00);
      rd(1'b1, v);
      chk(v, 8'h17);
      for (int d = 1; d >= 0; d--) begin
         key(1);
         wr(1'b1, 8'h10 | 8'(d));
         goSleep(SMC_SEL_POWER_DOWN_MODE, 1'b1);
         chk({7'h00, pwr.regFull}, 8'(d));
         chk({7'h00, pwr.leakCut}, 8'(1 - d));
         wake(2, SMC_SEL_POWER_DOWN_MODE);
      end
      repeat (3) @(posedge core_clk);
      #1 chk({7'h00, pwr.regFull}, 8'h01);
      slowSourceSel <= 1'b1;
      repeat (3) @(posedge core_clk);
      #1 chk({7'h00, pwr.regFull}, 8'h00);
      tally_and_finish();
   end
endmodule // sleep_mode_controller_test

// *** verification/smc_partner_model.sv ***
// Start-up model of the main oscillator, regulator and brown-out monitor.
`timescale 1ns/1ps
module smc_partner_model
   import smc_pkg::*;
(
   input  wire logic       core_clk,
   input  wire logic       reset,
   input  wire smc_state_t stateOut,
   input  wire logic [7:0] oscDly,
   input  wire logic [7:0] bodDly,
   output logic            oscReady,
   output logic            regReady,
   output logic            bodReady
);
   logic [7:0] upCnt_reg;
   logic       deep_reg;
   // Any sleep restarts the count, so slow start-up is seen after every wake.
   always_ff @(posedge core_clk) begin
      if (reset || stateOut inside {SMC_IDLE, SMC_STANDBY, SMC_POWER_DOWN_MODE}) begin
         upCnt_reg <= 8'h00;
      end else if (upCnt_reg != 8'hFF) begin
         upCnt_reg <= upCnt_reg + 8'h01;
      end
   end
   // Only Standby and Power-Down stop the oscillator and regulator; Idle keeps them.
   always_ff @(posedge core_clk) begin
      if (reset || stateOut == SMC_ACTIVE) begin
         deep_reg <= 1'b0;
      end else if (stateOut inside {SMC_STANDBY, SMC_POWER_DOWN_MODE}) begin
         deep_reg <= 1'b1;
      end
   end
   assign oscReady = !deep_reg || upCnt_reg >= oscDly;
   assign regReady = oscReady;
   assign bodReady = upCnt_reg >= bodDly;
endmodule // smc_partner_model

// *** verification/smc_sleep_mode_controller_properties.sv ***
// Port assertions for the sleep mode controller.
`timescale 1ns/1ps
module smc_sleep_mode_controller_properties
   import smc_pkg::*;
(
   input wire logic       core_clk,
   input wire logic       reset,
   input wire logic       wakeIdleReq,
   input wire logic       debugBreak,
   input wire logic       runInStandby,
   input wire logic       oscReady,
   input wire smc_pwr_t   pwr,
   input wire smc_state_t stateOut
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   // Any of the three low-power states; pwr and stateOut share one register stage, so three-cycle runs only add margin.
   wire logic slp = stateOut inside {SMC_IDLE, SMC_STANDBY, SMC_POWER_DOWN_MODE};
   a_cpu_stopped: assert property (slp [*3] |-> !pwr.cpuRun)
      else $error("cpu runs in sleep");
   a_idle_clock: assert property (stateOut == SMC_IDLE [*3] |-> pwr.mainClkRun)
      else $error("main clock stopped in idle");
   a_power_down_mode_clocks: assert property (stateOut == SMC_POWER_DOWN_MODE [*3] |-> !pwr.mainClkRun && !pwr.hfClkRun)
      else $error("clock runs in power down");
   a_standby_fast: assert property ((stateOut == SMC_STANDBY && !runInStandby) [*3] |-> !pwr.hfClkRun)
      else $error("fast clock runs in standby");
   a_fixed_delay: assert property ($rose(stateOut == SMC_WAKE_FIX) |->
      (stateOut == SMC_WAKE_FIX) [*6] ##1 stateOut != SMC_WAKE_FIX)
      else $error("fixed wake delay wrong");
   // State and power controls leave the same register stage, so no lag is needed here.
   a_power_down_mode_slow: assert property (stateOut == SMC_POWER_DOWN_MODE |-> pwr.slowOscOnly)
      else $error("slow oscillator flag missing in power down");
   a_debug_wake: assert property (slp && debugBreak |-> ##[1:3] !slp)
      else $error("debug break did not wake");
   a_idle_wake: assert property (stateOut == SMC_IDLE && wakeIdleReq |-> ##[1:3] stateOut == SMC_WAKE_FIX)
      else $error("idle wake not started");
   a_osc_hold: assert property (stateOut == SMC_WAKE_OSC && !oscReady |-> ##1 stateOut == SMC_WAKE_OSC)
      else $error("left oscillator wait early");
   c_power_down_mode: cover property (stateOut == SMC_POWER_DOWN_MODE);
   c_osc: cover property (stateOut == SMC_WAKE_OSC);
   c_bod: cover property (stateOut == SMC_WAKE_BOD);
endmodule // smc_sleep_mode_controller_properties

bind smc_sleep_mode_controller smc_sleep_mode_controller_properties smc_props_inst (.core_clk,
   .reset, .wakeIdleReq, .debugBreak, .runInStandby, .oscReady, .pwr, .stateOut);
